// ===== logic/irq_collector_pkg.sv
package irq_collector_pkg;

   // ==========================================================
   // Level-2 unit indices
   localparam int NUM_L2          = 7;
   localparam int U_TOUCH         = 0;
   localparam int U_AUDIO         = 1;
   localparam int U_KEYSCAN       = 2;
   localparam int U_GPIO_LOW      = 3;
   localparam int U_DEBUG_SERIAL  = 4;
   localparam int U_GPIO_HIGH     = 5;
   localparam int U_INFRARED      = 6;

   // ==========================================================
   // Register offsets
   localparam logic [31:0] SYS_IRQ_STATUS1_OFF        = 32'h0B00_0080;
   localparam logic [31:0] TOUCH_PANEL_IRQ_STATUS_OFF = 32'h0B00_0082;
   localparam logic [31:0] AUDIO_IRQ_STATUS_OFF       = 32'h0B00_0084;
   localparam logic [31:0] KEYSCAN_IRQ_STATUS_OFF     = 32'h0B00_0086;
   localparam logic [31:0] GPIO_LOW_IRQ_STATUS_OFF    = 32'h0B00_0088;
   localparam logic [31:0] DEBUG_SERIAL_IRQ_STATUS_OFF = 32'h0B00_008A;
   localparam logic [31:0] SYS_IRQ_ENABLE1_OFF        = 32'h0B00_008C;
   localparam logic [31:0] TOUCH_PANEL_IRQ_ENABLE_OFF = 32'h0B00_008E;
   localparam logic [31:0] AUDIO_IRQ_ENABLE_OFF       = 32'h0B00_0090;
   localparam logic [31:0] KEYSCAN_IRQ_ENABLE_OFF     = 32'h0B00_0092;
   localparam logic [31:0] GPIO_LOW_IRQ_ENABLE_OFF    = 32'h0B00_0094;
   localparam logic [31:0] DEBUG_SERIAL_IRQ_ENABLE_OFF = 32'h0B00_0096;
   localparam logic [31:0] NONMASKABLE_ROUTE_SELECT_OFF = 32'h0B00_0098;
   localparam logic [31:0] SOFTWARE_IRQ_TRIGGER_OFF   = 32'h0B00_009A;
   localparam logic [31:0] SYS_IRQ_STATUS2_OFF        = 32'h0B00_0200;
   localparam logic [31:0] GPIO_HIGH_IRQ_STATUS_OFF   = 32'h0B00_0202;
   localparam logic [31:0] INFRARED_IRQ_STATUS_OFF    = 32'h0B00_0204;
   localparam logic [31:0] SYS_IRQ_ENABLE2_OFF        = 32'h0B00_0206;
   localparam logic [31:0] GPIO_HIGH_IRQ_ENABLE_OFF   = 32'h0B00_0208;
   localparam logic [31:0] INFRARED_IRQ_ENABLE_OFF    = 32'h0B00_020A;

   localparam logic [NUM_L2-1:0][31:0] L2_STATUS_OFF = {
      INFRARED_IRQ_STATUS_OFF, GPIO_HIGH_IRQ_STATUS_OFF,
      DEBUG_SERIAL_IRQ_STATUS_OFF, GPIO_LOW_IRQ_STATUS_OFF,
      KEYSCAN_IRQ_STATUS_OFF, AUDIO_IRQ_STATUS_OFF,
      TOUCH_PANEL_IRQ_STATUS_OFF};
   localparam logic [NUM_L2-1:0][31:0] L2_ENABLE_OFF = {
      INFRARED_IRQ_ENABLE_OFF, GPIO_HIGH_IRQ_ENABLE_OFF,
      DEBUG_SERIAL_IRQ_ENABLE_OFF, GPIO_LOW_IRQ_ENABLE_OFF,
      KEYSCAN_IRQ_ENABLE_OFF, AUDIO_IRQ_ENABLE_OFF,
      TOUCH_PANEL_IRQ_ENABLE_OFF};

   // ==========================================================
   // Level-1 register 1 bit positions
   localparam int SYS1_TOUCH_SUSPEND_BIT = 13;
   localparam int SYS1_SOFTWARE_BIT      = 11;
   localparam int SYS1_BUS_ERROR_BIT     = 10;
   localparam int SYS1_SERIAL_BIT        = 9;
   localparam int SYS1_GPIO_LOW_BIT      = 8;
   localparam int SYS1_KEYSCAN_BIT       = 7;
   localparam int SYS1_AUDIO_BIT         = 6;
   localparam int SYS1_TOUCH_BIT         = 5;
   localparam int SYS1_ELAPSED_BIT       = 3;
   localparam int SYS1_TIMER_LONG_1_BIT  = 2;
   localparam int SYS1_POWER_SWITCH_BIT  = 1;
   localparam int SYS1_BATTERY_BIT       = 0;

   // Level-1 register 2 bit positions
   localparam int SYS2_TIMER_LONG_2_BIT  = 0;
   localparam int SYS2_HSP_BIT           = 1;
   localparam int SYS2_GPIO_HIGH_BIT     = 2;
   localparam int SYS2_INFRARED_BIT      = 3;

   // ==========================================================
   // Level-2, route select and software trigger field positions
   localparam int TOUCH_CMD_SCAN_BIT     = 6;
   localparam int TOUCH_ADC_PORT_BIT     = 5;
   localparam int TOUCH_PAGE1_BIT        = 4;
   localparam int TOUCH_PAGE0_BIT        = 3;
   localparam int TOUCH_ADC_TIMEOUT_BIT  = 2;
   localparam int TOUCH_CONTACT_BIT      = 0;
   localparam int MIC_PAGE2_BIT          = 11;
   localparam int MIC_PAGE1_BIT          = 10;
   localparam int MIC_OVERRUN_BIT        = 9;
   localparam int MIC_RX_DONE_BIT        = 8;
   localparam int SPK_PAGE2_BIT          = 3;
   localparam int SPK_PAGE1_BIT          = 2;
   localparam int SPK_UNDERRUN_BIT       = 1;
   localparam int NMI_ROUTE_BIT          = 0;
   localparam int SOFT_TRIGGER_BIT       = 0;

   // ==========================================================
   // Implemented bits; all others read zero
   localparam logic [15:0] SYS1_VALID     = 16'h2FEF;
   localparam logic [15:0] SYS2_VALID     = 16'h000F;
   localparam logic [15:0] TOUCH_VALID    = 16'h007D;
   localparam logic [15:0] AUDIO_VALID    = 16'h0F0E;
   localparam logic [15:0] KEYSCAN_VALID  = 16'h0007;
   localparam logic [15:0] GPIO_VALID     = 16'hFFFF;
   localparam logic [15:0] DSERIAL_VALID  = 16'h0F00;
   localparam logic [15:0] INFRARED_VALID = 16'h0007;
   localparam logic [15:0] SINGLE_VALID   = 16'h0001;
   localparam logic [NUM_L2-1:0][15:0] L2_VALID = {
      INFRARED_VALID, GPIO_VALID, DSERIAL_VALID, GPIO_VALID,
      KEYSCAN_VALID, AUDIO_VALID, TOUCH_VALID};

   // ==========================================================
   // Reset values
   localparam logic [15:0] STATUS_RESET   = 16'h0000;
   localparam logic [15:0] ENABLE_RESET   = 16'h0000;
   localparam logic [15:0] NMI_SEL_RESET  = 16'h0000;
   localparam logic [15:0] SOFT_RESET     = 16'h0000;
   localparam logic [15:0] READ_IDLE      = 16'h0000;

   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS  = 100;
   localparam int MEMDRV_TIME_NS = 1000;
   localparam int MEMDRV_CYCLES  =
      (MEMDRV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ==========================================================
   // Suspend sequencing
   typedef enum logic [2:0] {
      ST_RUN     = 3'b001,
      ST_SUSPEND = 3'b010,
      ST_RESUME  = 3'b100
   } power_state_t;

endpackage

// ===== logic/two_level_interrupt_collector.sv
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
module two_level_interrupt_collector #(
   parameter int MEMDRV_CYCLES = irq_collector_pkg::MEMDRV_CYCLES
) (
   input  wire logic        sys_clk,
   input  wire logic        rst_b,
   input  wire logic        clk_en,
   input  wire logic        rtc_domain_reset_b,
   input  wire logic [31:0] reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   input  wire logic [15:0] touch_panel_req,
   input  wire logic [15:0] audio_req,
   input  wire logic [15:0] keyscan_req,
   input  wire logic [15:0] gpio_low_req,
   input  wire logic [15:0] debug_serial_req,
   input  wire logic [15:0] gpio_high_req,
   input  wire logic [15:0] infrared_req,
   input  wire logic        battery_req,
   input  wire logic        power_switch_req,
   input  wire logic        timer_long_1_request,
   input  wire logic        timer_long_2_request,
   input  wire logic        elapsed_timer_req,
   input  wire logic        bus_error_req,
   input  wire logic        serial_unit_req,
   input  wire logic        hsp_req,
   input  wire logic        suspend_mode,
   output logic             core_irq_line_0,
   output logic             core_irq_line_1,
   output logic             core_irq_line_2,
   output logic             core_irq_line_3,
   output logic             core_nmi,
   output logic             int_all,
   output logic             memory_drive
);

   localparam int NL2 = irq_collector_pkg::NUM_L2;
   localparam logic [15:0] CNT_LOAD = 16'(MEMDRV_CYCLES);

   // ==========================================================
   // Declarations
   logic [NL2-1:0][15:0] l2_req;
   logic [NL2-1:0][15:0] level2_status_r;
   logic [NL2-1:0][15:0] level2_enable_r;
   logic [NL2-1:0]       l2_any;
   logic [15:0]          level1_status1_r;
   logic [15:0]          level1_status2_r;
   logic [15:0]          level1_enable1_r;
   logic [15:0]          level1_enable2_r;
   logic [15:0]          nmi_select_r;
   logic [15:0]          soft_trigger_r;
   logic [15:0]          level1_status1_nxt;
   logic [15:0]          level1_status2_nxt;
   logic [15:0]          masked1;
   logic [15:0]          masked2;
   logic                 status_clear;
   logic                 wr_sel_nmi;
   logic                 wr_sel_soft;
   logic                 nmi_route;
   logic                 line0_any;
   logic                 any_pending;
   logic                 core_gate;
   logic [15:0]          read_mux;
   logic [15:0]          memdrv_cnt_r;
   irq_collector_pkg::power_state_t pstate_r;
   irq_collector_pkg::power_state_t pstate_nxt;

   assign status_clear = !rst_b || !rtc_domain_reset_b;

   // ==========================================================
   // Write selects for single-bit control registers
   assign wr_sel_nmi  = clk_en && reg_wr &&
      (reg_addr == irq_collector_pkg::NONMASKABLE_ROUTE_SELECT_OFF);
   assign wr_sel_soft = clk_en && reg_wr &&
      (reg_addr == irq_collector_pkg::SOFTWARE_IRQ_TRIGGER_OFF);

   assign l2_req[irq_collector_pkg::U_TOUCH]        = touch_panel_req;
   assign l2_req[irq_collector_pkg::U_AUDIO]        = audio_req;
   assign l2_req[irq_collector_pkg::U_KEYSCAN]      = keyscan_req;
   assign l2_req[irq_collector_pkg::U_GPIO_LOW]     = gpio_low_req;
   assign l2_req[irq_collector_pkg::U_DEBUG_SERIAL] = debug_serial_req;
   assign l2_req[irq_collector_pkg::U_GPIO_HIGH]    = gpio_high_req;
   assign l2_req[irq_collector_pkg::U_INFRARED]     = infrared_req;

   // ==========================================================
   // Level-2 status and enable registers
   for (genvar u = 0; u < NL2; u++) begin : g_l2
      always_ff @(posedge sys_clk) begin
         if (status_clear) begin
            level2_status_r[u] <= irq_collector_pkg::STATUS_RESET;
         end else if (clk_en) begin
            // Bit follows its request; reserved positions stay zero
            level2_status_r[u] <= l2_req[u] &
                                  irq_collector_pkg::L2_VALID[u];
         end
      end

      always_ff @(posedge sys_clk) begin
         if (status_clear) begin
            level2_enable_r[u] <= irq_collector_pkg::ENABLE_RESET;
         end else if (clk_en && reg_wr &&
                      reg_addr == irq_collector_pkg::L2_ENABLE_OFF[u]) begin
            level2_enable_r[u] <= reg_wdata &
                                  irq_collector_pkg::L2_VALID[u];
         end
      end

      // One merged request per level-2 register
      assign l2_any[u] = |(level2_status_r[u] &
                           level2_enable_r[u]);
   end

   // ==========================================================
   // Level-1 indication
   always_comb begin
      level1_status1_nxt = irq_collector_pkg::STATUS_RESET;
      level1_status1_nxt[irq_collector_pkg::SYS1_TOUCH_SUSPEND_BIT] =
         l2_any[irq_collector_pkg::U_TOUCH] &&
         (pstate_r != irq_collector_pkg::ST_RUN);
      level1_status1_nxt[irq_collector_pkg::SYS1_SOFTWARE_BIT] =
         soft_trigger_r[irq_collector_pkg::SOFT_TRIGGER_BIT];
      level1_status1_nxt[irq_collector_pkg::SYS1_BUS_ERROR_BIT] =
         bus_error_req;
      level1_status1_nxt[irq_collector_pkg::SYS1_SERIAL_BIT] =
         serial_unit_req;
      level1_status1_nxt[irq_collector_pkg::SYS1_GPIO_LOW_BIT] =
         l2_any[irq_collector_pkg::U_GPIO_LOW] ||
         l2_any[irq_collector_pkg::U_DEBUG_SERIAL];
      level1_status1_nxt[irq_collector_pkg::SYS1_KEYSCAN_BIT] =
         l2_any[irq_collector_pkg::U_KEYSCAN];
      level1_status1_nxt[irq_collector_pkg::SYS1_AUDIO_BIT] =
         l2_any[irq_collector_pkg::U_AUDIO];
      level1_status1_nxt[irq_collector_pkg::SYS1_TOUCH_BIT] =
         l2_any[irq_collector_pkg::U_TOUCH];
      level1_status1_nxt[irq_collector_pkg::SYS1_ELAPSED_BIT] =
         elapsed_timer_req;
      level1_status1_nxt[irq_collector_pkg::SYS1_TIMER_LONG_1_BIT] =
         timer_long_1_request;
      level1_status1_nxt[irq_collector_pkg::SYS1_POWER_SWITCH_BIT] =
         power_switch_req;
      level1_status1_nxt[irq_collector_pkg::SYS1_BATTERY_BIT] =
         battery_req;
   end

   always_comb begin
      level1_status2_nxt = irq_collector_pkg::STATUS_RESET;
      level1_status2_nxt[irq_collector_pkg::SYS2_TIMER_LONG_2_BIT] =
         timer_long_2_request;
      level1_status2_nxt[irq_collector_pkg::SYS2_HSP_BIT] = hsp_req;
      level1_status2_nxt[irq_collector_pkg::SYS2_GPIO_HIGH_BIT] =
         l2_any[irq_collector_pkg::U_GPIO_HIGH];
      level1_status2_nxt[irq_collector_pkg::SYS2_INFRARED_BIT] =
         l2_any[irq_collector_pkg::U_INFRARED];
   end

   always_ff @(posedge sys_clk) begin
      if (status_clear) begin
         level1_status1_r <= irq_collector_pkg::STATUS_RESET;
         level1_status2_r <= irq_collector_pkg::STATUS_RESET;
      end else if (clk_en) begin
         level1_status1_r <= level1_status1_nxt;
         level1_status2_r <= level1_status2_nxt;
      end
   end

   // ==========================================================
   // Level-1 enables, route select, software trigger
   always_ff @(posedge sys_clk) begin
      if (status_clear) begin
         level1_enable1_r <= irq_collector_pkg::ENABLE_RESET;
         level1_enable2_r <= irq_collector_pkg::ENABLE_RESET;
      end else if (clk_en && reg_wr) begin
         case (reg_addr)
            irq_collector_pkg::SYS_IRQ_ENABLE1_OFF: begin
               level1_enable1_r <= reg_wdata &
                                   irq_collector_pkg::SYS1_VALID;
            end
            irq_collector_pkg::SYS_IRQ_ENABLE2_OFF: begin
               level1_enable2_r <= reg_wdata &
                                   irq_collector_pkg::SYS2_VALID;
            end
            default: begin
            end
         endcase
      end
   end

   // Battery route select
   always_ff @(posedge sys_clk) begin
      if (status_clear) begin
         nmi_select_r <= irq_collector_pkg::NMI_SEL_RESET;
      end else if (wr_sel_nmi) begin
         nmi_select_r <= reg_wdata &
                         irq_collector_pkg::SINGLE_VALID;
      end
   end

   // Software trigger
   always_ff @(posedge sys_clk) begin
      if (status_clear) begin
         soft_trigger_r <= irq_collector_pkg::SOFT_RESET;
      end else if (wr_sel_soft) begin
         soft_trigger_r <= reg_wdata &
                           irq_collector_pkg::SINGLE_VALID;
      end
   end

   // ==========================================================
   // Core line routing
   assign masked1   = level1_status1_r & level1_enable1_r;
   assign masked2   = level1_status2_r & level1_enable2_r;
   assign nmi_route = nmi_select_r[irq_collector_pkg::NMI_ROUTE_BIT];

   always_comb begin
      logic [15:0] rest1;
      rest1 = masked1;
      rest1[irq_collector_pkg::SYS1_TIMER_LONG_1_BIT] = 1'b0;
      rest1[irq_collector_pkg::SYS1_BATTERY_BIT]      =
         masked1[irq_collector_pkg::SYS1_BATTERY_BIT] && !nmi_route;
      line0_any = (|rest1) ||
         masked2[irq_collector_pkg::SYS2_GPIO_HIGH_BIT] ||
         masked2[irq_collector_pkg::SYS2_INFRARED_BIT];
   end

   assign any_pending = (|masked1) || (|masked2);
   // Core lines held off while suspended or until memory drive ends
   assign core_gate   = (pstate_r == irq_collector_pkg::ST_RUN);

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         core_irq_line_0 <= 1'b0;
         core_irq_line_1 <= 1'b0;
         core_irq_line_2 <= 1'b0;
         core_irq_line_3 <= 1'b0;
         core_nmi        <= 1'b0;
      end else if (clk_en) begin
         core_irq_line_0 <= core_gate && line0_any;
         core_irq_line_1 <= core_gate &&
            masked1[irq_collector_pkg::SYS1_TIMER_LONG_1_BIT];
         core_irq_line_2 <= core_gate &&
            masked2[irq_collector_pkg::SYS2_TIMER_LONG_2_BIT];
         core_irq_line_3 <= core_gate &&
            masked2[irq_collector_pkg::SYS2_HSP_BIT];
         core_nmi        <= core_gate && nmi_route &&
            masked1[irq_collector_pkg::SYS1_BATTERY_BIT];
      end
   end

   // General interrupt-source level, not held off by suspend
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         int_all <= 1'b0;
      end else if (clk_en) begin
         int_all <= any_pending;
      end
   end

   // ==========================================================
   // Suspend and resume sequencing
   always_comb begin
      pstate_nxt = pstate_r;
      case (pstate_r)
         irq_collector_pkg::ST_RUN: begin
            if (suspend_mode) begin
               pstate_nxt = irq_collector_pkg::ST_SUSPEND;
            end
         end
         irq_collector_pkg::ST_SUSPEND: begin
            if (!suspend_mode || any_pending) begin
               pstate_nxt = irq_collector_pkg::ST_RESUME;
            end
         end
         irq_collector_pkg::ST_RESUME: begin
            if (memdrv_cnt_r == 16'h0001) begin
               pstate_nxt = irq_collector_pkg::ST_RUN;
            end
         end
         default: begin
            pstate_nxt = irq_collector_pkg::ST_RUN;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         pstate_r <= irq_collector_pkg::ST_RUN;
      end else if (clk_en) begin
         pstate_r <= pstate_nxt;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         memdrv_cnt_r <= 16'h0000;
         memory_drive <= 1'b0;
      end else if (clk_en) begin
         if (pstate_r == irq_collector_pkg::ST_SUSPEND &&
             pstate_nxt == irq_collector_pkg::ST_RESUME) begin
            memdrv_cnt_r <= CNT_LOAD;
            memory_drive <= 1'b1;
         end else if (memdrv_cnt_r != 16'h0000) begin
            memdrv_cnt_r <= memdrv_cnt_r - 16'h0001;
            memory_drive <= (memdrv_cnt_r != 16'h0001);
         end else begin
            memory_drive <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Read decode
   always_comb begin
      read_mux = irq_collector_pkg::READ_IDLE;
      case (reg_addr)
         irq_collector_pkg::SYS_IRQ_STATUS1_OFF: begin
            read_mux = level1_status1_r;
         end
         irq_collector_pkg::SYS_IRQ_ENABLE1_OFF: begin
            read_mux = level1_enable1_r;
         end
         irq_collector_pkg::SYS_IRQ_STATUS2_OFF: begin
            read_mux = level1_status2_r;
         end
         irq_collector_pkg::SYS_IRQ_ENABLE2_OFF: begin
            read_mux = level1_enable2_r;
         end
         irq_collector_pkg::NONMASKABLE_ROUTE_SELECT_OFF: begin
            read_mux = nmi_select_r;
         end
         irq_collector_pkg::SOFTWARE_IRQ_TRIGGER_OFF: begin
            read_mux = soft_trigger_r;
         end
         default: begin
            for (int u = 0; u < NL2; u++) begin
               if (reg_addr == irq_collector_pkg::L2_STATUS_OFF[u]) begin
                  read_mux = level2_status_r[u];
               end
               if (reg_addr == irq_collector_pkg::L2_ENABLE_OFF[u]) begin
                  read_mux = level2_enable_r[u];
               end
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         reg_rdata <= irq_collector_pkg::READ_IDLE;
      end else if (clk_en) begin
         reg_rdata <= reg_rd ? read_mux : irq_collector_pkg::READ_IDLE;
      end
   end

endmodule

// ===== tb/irq_collector_properties.sv
`timescale 1ns/1ps
// ======================================================
// Port checker
module irq_collector_properties #(
   parameter int MEMDRV_CYCLES = 10
) (
   input wire logic        sys_clk,
   input wire logic        rst_b,
   input wire logic        clk_en,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic        battery_req,
   input wire logic        timer_long_1_request,
   input wire logic        timer_long_2_request,
   input wire logic        hsp_req,
   input wire logic        suspend_mode,
   input wire logic        core_irq_line_1,
   input wire logic        core_irq_line_2,
   input wire logic        core_irq_line_3,
   input wire logic        core_nmi,
   input wire logic        memory_drive
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   int hi_r;
   always_ff @(posedge sys_clk) hi_r <= memory_drive ? hi_r + 1 : 0;
   sequence s_run2;
      clk_en ##1 clk_en;
   endsequence
   a_rdata_idle:
      assert property (clk_en && !reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data not idle");
   a_line3_src:
      assert property (s_run2 ##1 core_irq_line_3 |-> $past(hsp_req, 2))
      else $error("line 3 without its source");
   a_line2_src:
      assert property (s_run2 ##1 core_irq_line_2 |->
         $past(timer_long_2_request, 2)) else $error("line 2 bad source");
   a_line1_src:
      assert property (s_run2 ##1 core_irq_line_1 |->
         $past(timer_long_1_request, 2)) else $error("line 1 bad source");
   a_nmi_src:
      assert property (s_run2 ##1 core_nmi |-> $past(battery_req, 2))
      else $error("nmi without battery");
   a_reset_quiet:
      assert property (!$past(rst_b) |-> !core_nmi && !core_irq_line_3)
      else $error("output active after reset");
   a_memdrv_len:
      assert property ($past(rst_b) && $fell(memory_drive) |->
         hi_r == MEMDRV_CYCLES) else $error("memory drive length");
   a_memdrv_cause:
      assert property ($rose(memory_drive) |-> $past(suspend_mode, 2))
      else $error("memory drive without suspend");
endmodule
bind two_level_interrupt_collector irq_collector_properties #(
   .MEMDRV_CYCLES(MEMDRV_CYCLES)) u_props (.sys_clk, .rst_b, .clk_en,
   .reg_rd, .reg_rdata, .battery_req, .timer_long_1_request,
   .timer_long_2_request, .hsp_req, .suspend_mode, .core_irq_line_1,
   .core_irq_line_2, .core_irq_line_3, .core_nmi, .memory_drive);

// ===== tb/irq_source_model.sv
`timescale 1ns/1ps
// ======================================================
// Peripheral request sources, levels held until reloaded
module irq_source_model (
   input  wire logic             sys_clk,
   input  wire logic             load,
   input  wire logic [2:0]       idx,
   input  wire logic [15:0]      bits,
   output logic      [7:0][15:0] req
);
   initial req = '0;
   always @(posedge sys_clk) if (load) req[idx] <= bits;
endmodule

// ===== tb/tb.sv
`timescale 1ns/1ps
// ======================================================
// Testbench
module tb;
   localparam int MD = 2;
   logic             sys_clk = 0, rst_b = 0, rtc_domain_reset_b = 1;
   logic             reg_rd = 0, reg_wr = 0, suspend_mode = 0, ld = 0;
   logic             memory_drive;
   logic [2:0]       idx = 3'h0;
   logic [31:0]      reg_addr = 32'h0;
   logic [15:0]      reg_wdata = 16'h0, reg_rdata, bits = 16'h0;
   logic [5:0]       ln;
   logic [7:0][15:0] req;
   int               n_fail = 0, n_compared = 0, cyc = 0;
   always #50 sys_clk = ~sys_clk;
   irq_source_model src (.sys_clk, .load(ld), .idx, .bits, .req);
   two_level_interrupt_collector #(.MEMDRV_CYCLES(MD)) dut (.sys_clk,
      .rst_b, .clk_en(1'b1), .rtc_domain_reset_b, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .touch_panel_req(req[0]),
      .audio_req(req[1]), .keyscan_req(req[2]), .gpio_low_req(req[3]),
      .debug_serial_req(req[4]), .gpio_high_req(req[5]),
      .infrared_req(req[6]), .battery_req(req[7][0]),
      .power_switch_req(req[7][1]), .timer_long_1_request(req[7][2]),
      .timer_long_2_request(req[7][3]), .elapsed_timer_req(req[7][4]),
      .bus_error_req(req[7][5]), .serial_unit_req(req[7][6]),
      .hsp_req(req[7][7]), .suspend_mode, .core_irq_line_0(ln[1]),
      .core_irq_line_1(ln[2]), .core_irq_line_2(ln[3]),
      .core_irq_line_3(ln[4]), .core_nmi(ln[0]), .int_all(ln[5]),
      .memory_drive);
   task automatic report_and_stop;
      if (n_fail == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         report_and_stop;
      end
   end
   task automatic chk(input logic [15:0] got, exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic wr(input logic [31:0] ad, input logic [15:0] v);
      @(posedge sys_clk);
      {reg_wr, reg_addr, reg_wdata} <= {1'b1, ad, v};
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [31:0] ad, input logic [15:0] v);
      @(posedge sys_clk);
      {reg_rd, reg_addr} <= {1'b1, ad};
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, v);
   endtask
   task automatic put(input logic [2:0] i, input logic [15:0] v);
      @(posedge sys_clk);
      {ld, idx, bits} <= {1'b1, i, v};
      @(posedge sys_clk);
      ld <= 1'b0;
      tick(5);
   endtask
   task automatic t_reset;
      for (int i = 0; i < 21; i++)
         rd(32'h0B00_0080 + 32'(2 * i) + (i > 13 ? 32'h164 : 32'h0), 0);
   endtask
   task automatic t_regs;
      logic [15:0] vm [11] = '{16'h2FEF, 16'h007D, 16'h0F0E, 16'h0007,
         16'hFFFF, 16'h0F00, 16'h0001, 16'h0001, 16'h000F, 16'hFFFF, 16'h0007};
      for (int i = 0; i < 11; i++)
         wr(32'h0B00_008C + 32'(2 * i) + (i > 7 ? 32'h16A : 32'h0),
            vm[i]);
      for (int i = 0; i < 11; i++)
         rd(32'h0B00_008C + 32'(2 * i) + (i > 7 ? 32'h16A : 32'h0), vm[i]);
      wr(32'h0B00_0080, 16'h2FEF);
      rd(32'h0B00_0080, 16'h0800);
      chk({10'h0, ln}, 16'h0022);
      wr(32'h0B00_009A, 16'h0000);
      wr(32'h0B00_0098, 16'h0000);
      rd(32'h0B00_0080, 16'h0000);
   endtask
   task automatic t_level2;
      logic [15:0] sb [7] = '{16'h0020, 16'h0040, 16'h0080, 16'h0100,
         16'h0100, 16'h0004, 16'h0008};
      logic [31:0] sr;
      for (int u = 0; u < 7; u++) begin
         sr = u < 5 ? 32'h0B00_0080 : 32'h0B00_0200;
         put(3'(u), 16'hFFFF);
         rd(irq_collector_pkg::L2_STATUS_OFF[u],
            irq_collector_pkg::L2_VALID[u]);
         rd(sr, sb[u]);
         chk({10'h0, ln}, 16'h0022);
         wr(irq_collector_pkg::L2_ENABLE_OFF[u], 16'h0000);
         rd(sr, 16'h0000);
         wr(irq_collector_pkg::L2_ENABLE_OFF[u],
            irq_collector_pkg::L2_VALID[u]);
         put(3'(u), 16'h0000);
      end
   endtask
   task automatic t_direct;
      logic [5:0]  el [8] = '{34, 34, 36, 40, 34, 34, 34, 48};
      logic [15:0] es [8] = '{1, 2, 4, 0, 8, 16'h0400, 16'h0200, 0};
      for (int b = 0; b < 8; b++) begin
         put(3'h7, 16'(1 << b));
         chk({10'h0, ln}, {10'h0, el[b]});
         rd(32'h0B00_0080, es[b]);
      end
      wr(32'h0B00_0098, 16'h0001);
      put(3'h7, 16'h0001);
      chk({10'h0, ln}, 16'h0021);
      wr(32'h0B00_0098, 16'h0000);
      put(3'h7, 16'h0000);
   endtask
   task automatic t_suspend;
      int n = 0;
      @(posedge sys_clk);
      suspend_mode <= 1'b1;
      tick(3);
      suspend_mode <= 1'b0;
      #1;
      while (!memory_drive && n < 10) begin
         tick(1);
         #1;
         n++;
      end
      for (n = 0; memory_drive === 1'b1 && n < 20; n++) begin
         tick(1);
         #1;
      end
      chk(16'(n), 16'(MD));
   endtask
   task automatic t_rtc;
      @(posedge sys_clk);
      rtc_domain_reset_b <= 1'b0;
      @(posedge sys_clk);
      rtc_domain_reset_b <= 1'b1;
      rd(32'h0B00_008C, 16'h0000);
   endtask
   initial begin
      tick(16);
      rst_b <= 1'b1;
      t_reset;
      t_regs;
      t_level2;
      t_direct;
      t_suspend;
      t_rtc;
      report_and_stop;
   end
endmodule
